// ==== include/sim_pkg.sv ====
// package: register map, field positions, timing constants and carrier structs
//
// Contract
// - hold static reset while supply is low
// - drive reset pin low during low-voltage reset
// - threshold low, medium or high from configuration
// - low-voltage reset enabled by configuration setting
// - warning uses lower falling than rising threshold
// - warning level readable live, read only
// - warning works only with low-voltage reset enabled
// - warning thresholds follow selected reset threshold
// - each warning flag change raises a request
// - no rising request within the reset delay
// - enable before crossing gives two requests
// - wait mode unaffected, warning wakes from wait
// - halt freezes register, no wake from halt
// - request reaches cpu only enabled and unmasked
// - enable bit 6 read/write, pending cleared on entry
// - warning flag bit 5, hardware read only
// - reset flag bit 4 set by low-voltage reset
// - low-voltage flag survives pin and watchdog resets
// - watchdog flag bit 0, cleared by low-voltage reset
// - flags encode last reset source
// - bit 7 reads zero, bits 3:1 reserved zero
package sim_pkg;

    localparam logic [7:0]  SIM_REG_IDX_CSR    = 8'h25;
    localparam logic [11:0] SIM_ADDR_CSR       = {2'h0, SIM_REG_IDX_CSR, 2'h0};
    localparam logic [11:0] SIM_ADDR_CFG       = 12'h100;
    localparam int          SIM_BIT_IRQ_EN     = 6;
    localparam int          SIM_BIT_WARN_FLAG  = 5;
    localparam int          SIM_BIT_LV_FLAG    = 4;
    localparam int          SIM_BIT_WDG_FLAG   = 0;
    localparam logic [7:0]  SIM_CSR_RESET      = 8'h00;
    localparam logic [7:0]  SIM_CSR_WMASK      = 8'h51;
    localparam logic [1:0]  SIM_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  SIM_RESP_SLVERR    = 2'h2;
    localparam int          SIM_DELAY_SHORT    = 256;
    localparam int          SIM_DELAY_LONG     = 4096;
    localparam int          SIM_SYNC_STAGES    = 3;

    typedef enum logic [1:0] {SIM_THR_LOW, SIM_THR_MED, SIM_THR_HIGH, SIM_THR_RSVD} sim_thr_e;

    // non-volatile configuration latched at startup
    typedef struct packed {
        logic     lv_enable;
        sim_thr_e threshold;
        logic     long_delay;
    } sim_cfg_s;

    // raw analog comparator outputs (asynchronous)
    typedef struct packed {
        logic lv_below;
        logic warn_below;
    } sim_cmp_s;

    // cpu-side interrupt and power state hooks
    typedef struct packed {
        logic global_mask;
        logic isr_enter;
        logic in_wait;
        logic in_halt;
    } sim_cpu_s;

endpackage

// ==== rtl/sim_sync.sv ====
// three-flop synchroniser with agree-qualified output
module sim_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);
    import sim_pkg::*;

    logic [SIM_SYNC_STAGES-1:0] stg_q;

    // shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stg_q <= {SIM_SYNC_STAGES{RESET_VAL}};
        else
            stg_q <= {stg_q[SIM_SYNC_STAGES-2:0], async_in};
    end

    // output changes only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_out <= RESET_VAL;
        else if (stg_q[1] == stg_q[2])
            sync_out <= stg_q[2];
    end
endmodule

// ==== rtl/sim_top.sv ====
// supply integrity monitor: reset hold, warning interrupt, reset-source flags
//
// Chosen here: register access over AXI4-Lite.
module sim_top (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire sim_pkg::sim_cfg_s cfg,
    input  wire sim_pkg::sim_cmp_s cmp,
    input  wire sim_pkg::sim_cpu_s cpu,
    input  wire logic             wdg_reset,
    input  wire logic             pin_reset_n_i,
    output logic                  pin_reset_n_o,
    output logic                  pin_reset_n_oe,
    output logic                  sys_reset_n,
    output logic                  warn_irq,
    output logic                  wake_req,
    output sim_pkg::sim_thr_e     warn_thr_sel,
    output logic                  warn_cmp_en,
    input  wire logic [11:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [11:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready
);
    import sim_pkg::*;

    logic        lv_sync;
    logic        warn_sync;
    logic        pin_sync;
    logic        cfg_valid_q;
    sim_cfg_s    cfg_q;
    logic        lv_active;
    logic        warn_live;
    logic        warn_flag_q;
    logic        irq_en_q;
    logic        lv_flag_q;
    logic        wdg_flag_q;
    logic        pend_q;
    logic        lv_reset_q;
    logic        wdg_seen_q;
    logic [12:0] dly_cnt_q;
    logic        in_delay;
    logic        warn_edge;
    logic        en_rise;
    logic        frozen;
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_fire;
    logic        wr_hit;
    logic        cfg_hit;
    logic        rd_fire;
    logic [7:0]  csr_rd;
    logic [SIM_SYNC_STAGES+1:0] oe_hist_q;
    logic        ext_pin_rst;
    logic        csr_wr;

    // csr byte in its register layout; bit 7 and bits 3:1 read zero
    function automatic logic [7:0] csr_image(input logic ie, input logic wf,
                                             input logic lf, input logic df);
        logic [7:0] v;
        v = 8'h00;
        v[SIM_BIT_IRQ_EN]    = ie;
        v[SIM_BIT_WARN_FLAG] = wf;
        v[SIM_BIT_LV_FLAG]   = lf;
        v[SIM_BIT_WDG_FLAG]  = df;
        return v;
    endfunction

    // reload value of the post-reset delay counter
    function automatic logic [12:0] delay_load(input logic long_sel);
        return long_sel ? 13'(SIM_DELAY_LONG) : 13'(SIM_DELAY_SHORT);
    endfunction

    // comparator and pin inputs cross into the cpu clock domain;
    // the supply stage resets to good, the delay phase covers its latency
    sim_sync #(.RESET_VAL(1'b0)) u_sync_lv (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (cmp.lv_below),
        .sync_out (lv_sync)
    );
    sim_sync #(.RESET_VAL(1'b0)) u_sync_warn (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (cmp.warn_below),
        .sync_out (warn_sync)
    );
    sim_sync #(.RESET_VAL(1'b1)) u_sync_pin (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pin_reset_n_i),
        .sync_out (pin_sync)
    );

    // configuration captured once, the first cycle after reset release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_valid_q <= 1'b0;
            cfg_q       <= '0;
        end
        else if (!cfg_valid_q)
        begin
            cfg_valid_q <= 1'b1;
            cfg_q       <= cfg;
        end
    end

    // the analog block picks thresholds from the selected level
    assign warn_thr_sel = cfg_q.threshold;
    assign warn_cmp_en  = cfg_q.lv_enable;
    assign lv_active    = cfg_q.lv_enable & lv_sync;
    // hysteresis lives in the comparator; the synced output is the level
    assign warn_live    = cfg_q.lv_enable & warn_sync;

    // low-voltage reset latch and watchdog event capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lv_reset_q <= 1'b0;
            wdg_seen_q <= 1'b0;
        end
        else
        begin
            lv_reset_q <= lv_active;
            wdg_seen_q <= wdg_reset;
        end
    end

    // post-reset delay counter: 256 or 4096 cycles after any reset source
    // a source that is still active keeps restarting the full delay
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dly_cnt_q <= 13'(SIM_DELAY_LONG);
        else if (!cfg_valid_q)
            dly_cnt_q <= delay_load(cfg.long_delay);
        else if (lv_active || wdg_reset || ext_pin_rst)
            dly_cnt_q <= delay_load(cfg_q.long_delay);
        else if (dly_cnt_q != 13'h0000)
            dly_cnt_q <= dly_cnt_q - 13'h0001;
    end

    // delay phase also covers the cycle before the setting is captured
    assign in_delay = (dly_cnt_q != 13'h0000) | !cfg_valid_q;

    // static reset held for low supply, watchdog and the delay phase
    assign sys_reset_n    = !(lv_reset_q | in_delay);
    assign pin_reset_n_o  = 1'b0;
    assign pin_reset_n_oe = lv_reset_q | wdg_seen_q | in_delay;

    // the pin echoes our own pull back through its synchroniser, so a low
    // pin counts as an external reset only once that echo has died out
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            oe_hist_q <= '1;
        else
            oe_hist_q <= {oe_hist_q[SIM_SYNC_STAGES:0], pin_reset_n_oe};
    end

    assign ext_pin_rst = !pin_sync && !pin_reset_n_oe && (oe_hist_q == '0);

    // halt freezes the register and blocks new requests
    assign frozen = cpu.in_halt;

    // warning flag follows the synced comparator, also in delay; held in halt only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            warn_flag_q <= 1'b0;
        else if (in_delay)
            warn_flag_q <= warn_live;
        else if (!frozen)
            warn_flag_q <= warn_live;
    end

    assign warn_edge = !in_delay && !frozen && (warn_flag_q != warn_live);
    // enabling while the flag is high raises a request at once; not in halt
    assign en_rise   = csr_wr && wdata_q[SIM_BIT_IRQ_EN] && !irq_en_q && warn_flag_q;

    // pending request: set on toggle or on enabling while flag is high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_q <= 1'b0;
        else if (in_delay || !cfg_q.lv_enable)
            pend_q <= 1'b0;
        else if (irq_en_q && warn_edge)
            pend_q <= 1'b1; // set wins over clear
        else if (en_rise)
            pend_q <= 1'b1;
        else if (cpu.isr_enter)
            pend_q <= 1'b0;
    end

    // request to the cpu and wake from wait
    assign warn_irq = pend_q & irq_en_q & !cpu.global_mask;
    assign wake_req = pend_q & irq_en_q & cpu.in_wait & !cpu.in_halt;

    // interrupt enable bit: software read/write, frozen in halt
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_en_q <= SIM_CSR_RESET[SIM_BIT_IRQ_EN];
        else if (in_delay)
            irq_en_q <= 1'b0;
        else if (csr_wr)
            irq_en_q <= wdata_q[SIM_BIT_IRQ_EN];
    end

    // reset-source flags survive the block reset domain of the cpu
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lv_flag_q <= SIM_CSR_RESET[SIM_BIT_LV_FLAG];
        else if (lv_active)
            lv_flag_q <= 1'b1;
        else if (csr_wr && !wdata_q[SIM_BIT_LV_FLAG])
            lv_flag_q <= 1'b0;
    end

    // watchdog flag: set by watchdog, cleared by pin, low supply or software
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wdg_flag_q <= SIM_CSR_RESET[SIM_BIT_WDG_FLAG];
        else if (lv_active)
            wdg_flag_q <= 1'b0;
        else if (wdg_reset)
            wdg_flag_q <= 1'b1;
        else if (ext_pin_rst)
            wdg_flag_q <= 1'b0;
        else if (csr_wr && !wdata_q[SIM_BIT_WDG_FLAG])
            wdg_flag_q <= 1'b0;
    end

    // write channel: address and data accepted independently
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign wr_fire = aw_hold_q && w_hold_q;
    assign wr_hit  = wr_fire && (awaddr_q == SIM_ADDR_CSR);
    assign cfg_hit = wr_fire && (awaddr_q == SIM_ADDR_CFG);

    // register write decode; halt freezes the register against software
    assign csr_wr  = wr_hit && wstrb_q[0] && !frozen;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_hold_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_hold_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_hold_q <= 1'b0;
    end

    // write response one cycle after both halves are held
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SIM_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit || cfg_hit) ? SIM_RESP_OKAY : SIM_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read channel: one outstanding read, data registered
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign csr_rd  = csr_image(irq_en_q, warn_flag_q, lv_flag_q, wdg_flag_q);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= SIM_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == SIM_ADDR_CSR)
            begin
                s_axi_rdata <= {24'h000000, csr_rd};
                s_axi_rresp <= SIM_RESP_OKAY;
            end
            else if (s_axi_araddr == SIM_ADDR_CFG)
            begin
                s_axi_rdata <= {24'h000000, 3'h0, warn_sync, 4'h0} | 32'(cfg_q);
                s_axi_rresp <= SIM_RESP_OKAY;
            end
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= SIM_RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

// ==== tb/sim_assertions.sv ====
// checker: port-level timing relations of the supply integrity monitor
module sim_assertions (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire sim_pkg::sim_cfg_s cfg,
    input wire sim_pkg::sim_cmp_s cmp,
    input wire sim_pkg::sim_cpu_s cpu,
    input wire logic              pin_reset_n_o,
    input wire logic              pin_reset_n_oe,
    input wire logic              sys_reset_n,
    input wire logic              warn_irq,
    input wire logic              wake_req,
    input wire sim_pkg::sim_thr_e warn_thr_sel,
    input wire logic              warn_cmp_en,
    input wire logic [11:0]       s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    import sim_pkg::*;
    logic [11:0] rd_addr_q;
    // address of the read under way, to judge its answer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_addr_q <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr_q <= s_axi_araddr;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // low supply seen past the synchroniser holds the cpu and the pin in reset
    property p_lv_hold; (cfg.lv_enable && cmp.lv_below) [*6] |-> !sys_reset_n; endproperty
    a_lv_hold: assert property (p_lv_hold)
        else $error("cpu out of reset with supply low");
    property p_lv_pin; (cfg.lv_enable && cmp.lv_below) [*6] |-> pin_reset_n_oe; endproperty
    a_lv_pin: assert property (p_lv_pin)
        else $error("reset pin not driven with supply low");
    property p_pin_lvl; pin_reset_n_oe |-> !pin_reset_n_o; endproperty
    a_pin_lvl: assert property (p_pin_lvl)
        else $error("reset pin driven high");
    // analog hooks follow the latched setting once the cpu runs
    property p_cfg; sys_reset_n |-> warn_cmp_en == cfg.lv_enable && warn_thr_sel == cfg.threshold;
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("warning comparator setting differs");
    // request gating by mask and power state
    property p_mask; warn_irq |-> !cpu.global_mask; endproperty
    a_mask: assert property (p_mask)
        else $error("request with global mask set");
    property p_wake; wake_req |-> cpu.in_wait && !cpu.in_halt; endproperty
    a_wake: assert property (p_wake)
        else $error("wake outside wait or in halt");
    // read channel timing and register content
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer late");
    property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read answer dropped");
    property p_rsvd; s_axi_rvalid && rd_addr_q == SIM_ADDR_CSR |-> s_axi_rdata[7] == 1'b0
        && s_axi_rdata[3:1] == 3'h0 && s_axi_rresp == SIM_RESP_OKAY; endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits not zero");
    c_irq: cover property (warn_irq);
    c_wake: cover property (wake_req);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == SIM_RESP_SLVERR);
endmodule

bind sim_top sim_assertions sim_assertions_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .cmp(cmp),
    .cpu(cpu), .pin_reset_n_o(pin_reset_n_o), .pin_reset_n_oe(pin_reset_n_oe),
    .sys_reset_n(sys_reset_n), .warn_irq(warn_irq), .wake_req(wake_req),
    .warn_thr_sel(warn_thr_sel), .warn_cmp_en(warn_cmp_en), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== tb/sim_top_test.sv ====
// self-checking bench for the supply integrity monitor
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module sim_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sim_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    sim_cfg_s    cfg = 4'b1010;
    sim_cmp_s    cmp = 2'b00;
    sim_cpu_s    cpu = 4'b0000;
    logic        wdg = 1'b0;
    logic        pin_ext_n = 1'b1;
    wire logic   pin_lvl;
    logic        pin_o, pin_oe, sys_rst_n, irq, wake, cmp_en, awready, wready, bvalid;
    logic        arready, rvalid, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    sim_thr_e    thr;
    logic [1:0]  bresp, rresp, r;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [7:0]  d;
    int          fail_count = 0, n_compared = 0, n;
    // open-drain pin: low when either side pulls it
    assign pin_lvl = pin_ext_n && !pin_oe;
    always #10 clk = ~clk;
    sim_top sim_top_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .cmp(cmp), .cpu(cpu),
        .wdg_reset(wdg), .pin_reset_n_i(pin_lvl), .pin_reset_n_o(pin_o), .pin_reset_n_oe(pin_oe),
        .sys_reset_n(sys_rst_n), .warn_irq(irq), .wake_req(wake), .warn_thr_sel(thr),
        .warn_cmp_en(cmp_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // wait for the cpu reset to end, with a warning blip inside the delay
    task automatic boot(output int k);
        k = 0;
        while (sys_rst_n !== 1'b1)
        begin
            @(posedge clk);
            k++;
            if (k == 60)
                cmp.warn_below <= 1'b1;
            if (k == 120)
                cmp.warn_below <= 1'b0;
        end
    endtask
    task automatic do_rst(input sim_cfg_s c, output int k);
        rst_n <= 1'b0;
        cfg <= c;
        cyc(2);
        rst_n <= 1'b1;
        boot(k);
    endtask
    // axi write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        rs = bresp;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata[7:0];
        rs = rresp;
    endtask
    task automatic chk(input logic [7:0] m, input logic [7:0] e);
        rd(SIM_ADDR_CSR, d, r);
        `CHK({r, d & m}, {SIM_RESP_OKAY, e})
    endtask
    task automatic isr;
        cpu.isr_enter <= 1'b1;
        cyc(1);
        cpu.isr_enter <= 1'b0;
        cyc(1);
    endtask
    task automatic wdg_pulse;
        wdg <= 1'b1;
        cyc(1);
        wdg <= 1'b0;
        cyc(2);
        boot(n);
    endtask
    task automatic conclude;
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #400000;
        fail_count++;
        conclude();
    end
    // main sequence
    initial
    begin
        do_rst(4'b1010, n);
        `CHK(n >= SIM_DELAY_SHORT && n <= SIM_DELAY_SHORT + 8, 1'b1)
        chk(8'hFF, SIM_CSR_RESET);
        rd(SIM_ADDR_CFG, d, r);
        `CHK(d[4:0], 5'h0A)
        wr(SIM_ADDR_CSR, 8'hFF, r);
        chk(8'hFF, 8'h40);
        `CHK(irq, 1'b0)
        cmp.warn_below <= 1'b1;
        cyc(8);
        chk(8'hFF, 8'h60);
        `CHK(irq, 1'b1)
        cpu.global_mask <= 1'b1;
        cyc(1);
        `CHK(irq, 1'b0)
        cpu <= 4'b0010;
        cyc(1);
        `CHK(wake, 1'b1)
        cpu.in_halt <= 1'b1;
        cyc(1);
        `CHK(wake, 1'b0)
        wr(SIM_ADDR_CSR, 8'h00, r);
        chk(8'h40, 8'h40);
        cpu <= 4'b0000;
        cyc(1);
        isr();
        `CHK(irq, 1'b0)
        cmp.warn_below <= 1'b0;
        cyc(8);
        `CHK(irq, 1'b1)
        wr(SIM_ADDR_CSR, 8'h00, r);
        isr();
        cmp.warn_below <= 1'b1;
        cyc(8);
        isr();
        wr(SIM_ADDR_CSR, 8'h40, r);
        cyc(2);
        `CHK(irq, 1'b1)
        isr();
        cmp.warn_below <= 1'b0;
        cyc(8);
        `CHK(irq, 1'b1)
        wdg_pulse();
        chk(8'h11, 8'h01);
        cmp.lv_below <= 1'b1;
        cyc(8);
        `CHK({sys_rst_n, pin_oe}, 2'b01)
        cmp.lv_below <= 1'b0;
        cyc(8);
        boot(n);
        chk(8'h11, 8'h10);
        wdg_pulse();
        chk(8'h11, 8'h11);
        pin_ext_n <= 1'b0;
        cyc(4);
        pin_ext_n <= 1'b1;
        cyc(2);
        boot(n);
        chk(8'h11, 8'h10);
        wr(SIM_ADDR_CSR, 8'h00, r);
        chk(8'h11, 8'h00);
        rd(12'h200, d, r);
        `CHK({r, d}, {SIM_RESP_SLVERR, 8'h00})
        wr(12'h200, 8'hFF, r);
        `CHK(r, SIM_RESP_SLVERR)
        for (int t = 0; t < 3; t++)
        begin
            do_rst({1'b1, t[1:0], 1'b0}, n);
            `CHK(thr, sim_thr_e'(t))
        end
        do_rst({1'b0, SIM_THR_HIGH, 1'b1}, n);
        `CHK(n >= SIM_DELAY_LONG && n <= SIM_DELAY_LONG + 8, 1'b1)
        `CHK(cmp_en, 1'b0)
        wr(SIM_ADDR_CSR, 8'h40, r);
        cmp <= 2'b11;
        cyc(8);
        `CHK({sys_rst_n, irq}, 2'b10)
        conclude();
    end
endmodule
